// ==== design/pifb_defs.svh ====
// Purpose: offsets, field positions and reset values of the peripheral flag bank
// Assumes: byte-wide registers on a plain strobe port
// Notes:   definitions only
`ifndef PIFB_DEFS_SVH
`define PIFB_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PIFB_ADDR_W          3
`define PIFB_OFF_SERIAL      3'h3
`define PIFB_OFF_TIMER       3'h4
`define PIFB_OFF_GATE        3'h5
`define PIFB_OFF_CAPCOMP     3'h6
`define PIFB_OFF_SYSTEM      3'h7

// ----------------------------------------
// implemented-bit masks and reset value
// ----------------------------------------
`define PIFB_MASK_SERIAL_SW  8'h0F
`define PIFB_MASK_TIMER      8'h3F
`define PIFB_MASK_GATE       8'h07
`define PIFB_MASK_CAPCOMP    8'h03
`define PIFB_MASK_SYSTEM     8'hE1
`define PIFB_RESET_VAL       8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define PIFB_BIT_A2_RX       7
`define PIFB_BIT_A2_TX       6
`define PIFB_BIT_A1_RX       5
`define PIFB_BIT_A1_TX       4
`define PIFB_BIT_SYS_SCAN    7
`define PIFB_BIT_SYS_CRC     6
`define PIFB_BIT_SYS_NVM     5
`define PIFB_BIT_SYS_WAVE    0

// ----------------------------------------
// field positions of the sticky flags
// ----------------------------------------
`define PIFB_BIT_S2_COLL     3
`define PIFB_BIT_S2_DONE     2
`define PIFB_BIT_S1_COLL     1
`define PIFB_BIT_S1_DONE     0
`define PIFB_BIT_T6_MATCH    5
`define PIFB_BIT_T5_OVF      4
`define PIFB_BIT_T4_MATCH    3
`define PIFB_BIT_T3_OVF      2
`define PIFB_BIT_T2_MATCH    1
`define PIFB_BIT_T1_OVF      0
`define PIFB_BIT_T5_GATE     2
`define PIFB_BIT_T3_GATE     1
`define PIFB_BIT_T1_GATE     0
`define PIFB_BIT_CC2         1
`define PIFB_BIT_CC1         0

`endif

// ==== design/pifb_pkg.sv ====
// Purpose: types of the peripheral flag bank
// Assumes: nothing
// Notes:   constants live in pifb_defs.svh
package pifb_pkg;

   typedef logic [7:0] pifb_byte_type;

   // capture/compare unit operating mode
   typedef enum logic [2:0]
   {
      PIFB_MODE_CAPTURE = 3'b001,
      PIFB_MODE_COMPARE = 3'b010,
      PIFB_MODE_PWM     = 3'b100
   } pifb_ccmode_type;

endpackage

// ==== design/pifb_sticky_reg.sv ====
// Purpose: one byte of sticky flags, hardware set, software write
// Assumes: set pulses synchronous to the clock
// Notes:   set beats a software clear in the same cycle
`timescale 1ns/1ps
module pifb_sticky_reg
#(
   parameter logic [7:0] MASK = 8'hFF
)
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // software side
   input  wire logic       wr_i,
   input  wire logic [7:0] wdata_i,
   // hardware events
   input  wire logic [7:0] set_i,
   // flags
   output logic      [7:0] flags_o
);

   logic [7:0] flags_q;
   logic [7:0] flags_d;
   wire  [7:0] base_w = wr_i ? wdata_i : flags_q;

   // a set landing with the clear still wins
   assign flags_d = (base_w | set_i) & MASK;
   assign flags_o = flags_q;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         flags_q <= 8'h00;
      else
         flags_q <= flags_d;
   end

endmodule

// ==== design/pifb_status_flag.sv ====
// Purpose: status flag that follows a buffer level, cleared by an access
// Assumes: level and access strobes synchronous to the clock
// Notes:   the access hides the level for one cycle until the source updates
`timescale 1ns/1ps
module pifb_status_flag
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // source level and clearing access
   input  wire logic level_i,
   input  wire logic access_i,
   // flag
   output logic      flag_o
);

   logic flag_q;
   logic flag_d;

   // buffer state lags the access by a cycle, so drop the flag at once
   assign flag_d = level_i & ~access_i;
   assign flag_o = flag_q;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         flag_q <= 1'b0;
      else
         flag_q <= flag_d;
   end

endmodule

// ==== design/pifb_flag_bank.sv ====
// Purpose: latched peripheral interrupt request flags, registers three to seven
// Assumes: single 25 MHz clock, event inputs are one-cycle pulses or levels
// Notes:   flags set regardless of any enable; no interrupt output here
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "pifb_defs.svh"

// Behaviour
// - port two rx flag tracks unread data
// - port two tx flag shows buffer empty
// - port one rx flag shows buffer full
// - port one tx flag shows buffer empty
// - sync two collision sets sticky flag
// - sync one collision sets sticky flag
// - sync two completion sets sticky flag
// - sync one completion sets sticky flag
// - even timer period matches set bits 1,3,5
// - odd timer overflows set bits 0,2,4
// - unimplemented bits always read zero
// - timer gate events set bits 2,1,0
// - capture event sets unit flag in capture mode only
// - compare match sets unit flag in compare mode only
// - memory scan event sets bit 7
// - checksum event sets bit 6
// - nonvolatile controller event sets bit 5
// - waveform generator event sets bit 0
// - flags set independent of any enable
module pifb_flag_bank
(
   // clock and reset
   input  wire logic                     MCLK_I,
   input  wire logic                     RST_N_I,
   // register port
   input  wire logic [`PIFB_ADDR_W-1:0]  ADDR_I,
   input  wire logic [7:0]               WDATA_I,
   input  wire logic                     WR_I,
   input  wire logic                     RD_I,
   output logic      [7:0]               RDATA_O,
   // asynchronous serial ports
   input  wire logic                     ASYNC2_RX_FULL_I,
   input  wire logic                     ASYNC2_TX_EMPTY_I,
   input  wire logic                     ASYNC1_RX_FULL_I,
   input  wire logic                     ASYNC1_TX_EMPTY_I,
   input  wire logic                     ASYNC2_RX_DATA_RD_I,
   input  wire logic                     ASYNC2_TX_DATA_WR_I,
   input  wire logic                     ASYNC1_RX_DATA_RD_I,
   input  wire logic                     ASYNC1_TX_DATA_WR_I,
   // synchronous serial ports
   input  wire logic                     SYNC2_COLLISION_I,
   input  wire logic                     SYNC2_DONE_I,
   input  wire logic                     SYNC1_COLLISION_I,
   input  wire logic                     SYNC1_DONE_I,
   // timers
   input  wire logic                     TIMER6_MATCH_I,
   input  wire logic                     TIMER5_OVERFLOW_I,
   input  wire logic                     TIMER4_MATCH_I,
   input  wire logic                     TIMER3_OVERFLOW_I,
   input  wire logic                     TIMER2_MATCH_I,
   input  wire logic                     TIMER1_OVERFLOW_I,
   input  wire logic                     TIMER5_GATE_I,
   input  wire logic                     TIMER3_GATE_I,
   input  wire logic                     TIMER1_GATE_I,
   // capture/compare units
   input  wire pifb_pkg::pifb_ccmode_type CAPCOMP2_MODE_I,
   input  wire logic                     CAPCOMP2_CAPTURE_I,
   input  wire logic                     CAPCOMP2_MATCH_I,
   input  wire pifb_pkg::pifb_ccmode_type CAPCOMP1_MODE_I,
   input  wire logic                     CAPCOMP1_CAPTURE_I,
   input  wire logic                     CAPCOMP1_MATCH_I,
   // system units
   input  wire logic                     MEMORY_SCAN_I,
   input  wire logic                     CHECKSUM_UNIT_I,
   input  wire logic                     NONVOLATILE_CTRL_I,
   input  wire logic                     WAVEFORM_GEN_I,
   // flag bytes for the enable and priority logic
   output logic      [7:0]               SERIAL_FLAGS_O,
   output logic      [7:0]               TIMER_FLAGS_O,
   output logic      [7:0]               GATE_FLAGS_O,
   output logic      [7:0]               CAPCOMP_FLAGS_O,
   output logic      [7:0]               SYSTEM_FLAGS_O
);

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   // one hit per mapped offset, shared by writes and reads
   wire hit_serial  = (ADDR_I == `PIFB_OFF_SERIAL);
   wire hit_timer   = (ADDR_I == `PIFB_OFF_TIMER);
   wire hit_gate    = (ADDR_I == `PIFB_OFF_GATE);
   wire hit_capcomp = (ADDR_I == `PIFB_OFF_CAPCOMP);
   wire hit_system  = (ADDR_I == `PIFB_OFF_SYSTEM);

   // writes to unmapped offsets hit nothing
   wire wr_serial   = WR_I & hit_serial;
   wire wr_timer    = WR_I & hit_timer;
   wire wr_gate     = WR_I & hit_gate;
   wire wr_capcomp  = WR_I & hit_capcomp;
   wire wr_system   = WR_I & hit_system;

   // ----------------------------------------
   // event vectors
   // ----------------------------------------
   // events reach the flags with no enable gating, so polling works
   wire [7:0] serial_set;
   wire [7:0] timer_set;
   wire [7:0] gate_set;
   wire [7:0] capcomp_set;
   wire [7:0] system_set;

   // sync ports: bus collision and transfer done
   assign serial_set[7:4]                = 4'h0;
   assign serial_set[`PIFB_BIT_S2_COLL]  = SYNC2_COLLISION_I;
   assign serial_set[`PIFB_BIT_S2_DONE]  = SYNC2_DONE_I;
   assign serial_set[`PIFB_BIT_S1_COLL]  = SYNC1_COLLISION_I;
   assign serial_set[`PIFB_BIT_S1_DONE]  = SYNC1_DONE_I;

   // timers: even ones match their period, odd ones overflow
   assign timer_set[7:6]                 = 2'h0;
   assign timer_set[`PIFB_BIT_T6_MATCH]  = TIMER6_MATCH_I;
   assign timer_set[`PIFB_BIT_T5_OVF]    = TIMER5_OVERFLOW_I;
   assign timer_set[`PIFB_BIT_T4_MATCH]  = TIMER4_MATCH_I;
   assign timer_set[`PIFB_BIT_T3_OVF]    = TIMER3_OVERFLOW_I;
   assign timer_set[`PIFB_BIT_T2_MATCH]  = TIMER2_MATCH_I;
   assign timer_set[`PIFB_BIT_T1_OVF]    = TIMER1_OVERFLOW_I;

   // timer gates
   assign gate_set[7:3]                  = 5'h00;
   assign gate_set[`PIFB_BIT_T5_GATE]    = TIMER5_GATE_I;
   assign gate_set[`PIFB_BIT_T3_GATE]    = TIMER3_GATE_I;
   assign gate_set[`PIFB_BIT_T1_GATE]    = TIMER1_GATE_I;

   // pwm mode has no event; each mode only sees its own cause
   wire cc2_cap = (CAPCOMP2_MODE_I == pifb_pkg::PIFB_MODE_CAPTURE) & CAPCOMP2_CAPTURE_I;
   wire cc1_cap = (CAPCOMP1_MODE_I == pifb_pkg::PIFB_MODE_CAPTURE) & CAPCOMP1_CAPTURE_I;
   wire cc2_cmp = (CAPCOMP2_MODE_I == pifb_pkg::PIFB_MODE_COMPARE) & CAPCOMP2_MATCH_I;
   wire cc1_cmp = (CAPCOMP1_MODE_I == pifb_pkg::PIFB_MODE_COMPARE) & CAPCOMP1_MATCH_I;
   assign capcomp_set[7:2]               = 6'h00;
   assign capcomp_set[`PIFB_BIT_CC2]     = cc2_cap | cc2_cmp;
   assign capcomp_set[`PIFB_BIT_CC1]     = cc1_cap | cc1_cmp;

   // system units
   assign system_set[`PIFB_BIT_SYS_SCAN] = MEMORY_SCAN_I;
   assign system_set[`PIFB_BIT_SYS_CRC]  = CHECKSUM_UNIT_I;
   assign system_set[`PIFB_BIT_SYS_NVM]  = NONVOLATILE_CTRL_I;
   assign system_set[4:1]                = 4'h0;
   assign system_set[`PIFB_BIT_SYS_WAVE] = WAVEFORM_GEN_I;

   // ----------------------------------------
   // sticky flag bytes
   // ----------------------------------------
   wire [7:0] serial_sw;
   wire [7:0] timer_q;
   wire [7:0] gate_q;
   wire [7:0] capcomp_q;
   wire [7:0] system_q;

   // masks keep unimplemented bits at zero; reset clears all
   pifb_sticky_reg #(.MASK(`PIFB_MASK_SERIAL_SW)) u_serial
   (
      .clk_i   (MCLK_I),
      .rst_n_i (RST_N_I),
      .wr_i    (wr_serial),
      .wdata_i (WDATA_I),
      .set_i   (serial_set),
      .flags_o (serial_sw)
   );

   pifb_sticky_reg #(.MASK(`PIFB_MASK_TIMER)) u_timer
   (
      .clk_i   (MCLK_I),
      .rst_n_i (RST_N_I),
      .wr_i    (wr_timer),
      .wdata_i (WDATA_I),
      .set_i   (timer_set),
      .flags_o (timer_q)
   );

   pifb_sticky_reg #(.MASK(`PIFB_MASK_GATE)) u_gate
   (
      .clk_i   (MCLK_I),
      .rst_n_i (RST_N_I),
      .wr_i    (wr_gate),
      .wdata_i (WDATA_I),
      .set_i   (gate_set),
      .flags_o (gate_q)
   );

   pifb_sticky_reg #(.MASK(`PIFB_MASK_CAPCOMP)) u_capcomp
   (
      .clk_i   (MCLK_I),
      .rst_n_i (RST_N_I),
      .wr_i    (wr_capcomp),
      .wdata_i (WDATA_I),
      .set_i   (capcomp_set),
      .flags_o (capcomp_q)
   );

   pifb_sticky_reg #(.MASK(`PIFB_MASK_SYSTEM)) u_system
   (
      .clk_i   (MCLK_I),
      .rst_n_i (RST_N_I),
      .wr_i    (wr_system),
      .wdata_i (WDATA_I),
      .set_i   (system_set),
      .flags_o (system_q)
   );

   // ----------------------------------------
   // read-only serial buffer flags
   // ----------------------------------------
   // software writes to these bits are ignored
   // an access drops its flag at once, then the level rules
   wire a2_rx;
   wire a2_tx;
   wire a1_rx;
   wire a1_tx;

   pifb_status_flag u_a2_rx
   (
      .clk_i    (MCLK_I),
      .rst_n_i  (RST_N_I),
      .level_i  (ASYNC2_RX_FULL_I),
      .access_i (ASYNC2_RX_DATA_RD_I),
      .flag_o   (a2_rx)
   );

   pifb_status_flag u_a2_tx
   (
      .clk_i    (MCLK_I),
      .rst_n_i  (RST_N_I),
      .level_i  (ASYNC2_TX_EMPTY_I),
      .access_i (ASYNC2_TX_DATA_WR_I),
      .flag_o   (a2_tx)
   );

   pifb_status_flag u_a1_rx
   (
      .clk_i    (MCLK_I),
      .rst_n_i  (RST_N_I),
      .level_i  (ASYNC1_RX_FULL_I),
      .access_i (ASYNC1_RX_DATA_RD_I),
      .flag_o   (a1_rx)
   );

   pifb_status_flag u_a1_tx
   (
      .clk_i    (MCLK_I),
      .rst_n_i  (RST_N_I),
      .level_i  (ASYNC1_TX_EMPTY_I),
      .access_i (ASYNC1_TX_DATA_WR_I),
      .flag_o   (a1_tx)
   );

   wire [7:0] serial_all;

   // buffer flags sit above the sticky bits
   assign serial_all[`PIFB_BIT_A2_RX] = a2_rx;
   assign serial_all[`PIFB_BIT_A2_TX] = a2_tx;
   assign serial_all[`PIFB_BIT_A1_RX] = a1_rx;
   assign serial_all[`PIFB_BIT_A1_TX] = a1_tx;
   assign serial_all[3:0]             = serial_sw[3:0];

   // ----------------------------------------
   // read mux and output registers
   // ----------------------------------------
   // unmapped offsets read zero
   wire [7:0] rd_mux =
      hit_serial  ? serial_all :
      hit_timer   ? timer_q    :
      hit_gate    ? gate_q     :
      hit_capcomp ? capcomp_q  :
      hit_system  ? system_q   : `PIFB_RESET_VAL;

   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [7:0] serial_out_q;
   logic [7:0] timer_out_q;
   logic [7:0] gate_out_q;
   logic [7:0] capcomp_out_q;
   logic [7:0] system_out_q;

   // read data stands only in the cycle after the strobe
   // idle zero keeps a stale byte off the bus
   assign rdata_d = RD_I ? rd_mux : 8'h00;

   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         rdata_q <= 8'h00;
      else
         rdata_q <= rdata_d;
   end

   // ----------------------------------------
   // flag byte copies
   // ----------------------------------------
   // one cycle behind the flags, so every output leaves a flop
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         serial_out_q <= 8'h00;
      else
         serial_out_q <= serial_all;
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         timer_out_q <= 8'h00;
      else
         timer_out_q <= timer_q;
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         gate_out_q <= 8'h00;
      else
         gate_out_q <= gate_q;
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         capcomp_out_q <= 8'h00;
      else
         capcomp_out_q <= capcomp_q;
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         system_out_q <= 8'h00;
      else
         system_out_q <= system_q;
   end

   assign RDATA_O         = rdata_q;
   assign SERIAL_FLAGS_O  = serial_out_q;
   assign TIMER_FLAGS_O   = timer_out_q;
   assign GATE_FLAGS_O    = gate_out_q;
   assign CAPCOMP_FLAGS_O = capcomp_out_q;
   assign SYSTEM_FLAGS_O  = system_out_q;

endmodule

// ==== tb/pifb_flag_bank_checker.sv ====
// Purpose: port checks of the flag bank
// Assumes: one clock, async low reset
// Notes:   flag bytes trail the flags by a cycle
`timescale 1ns/1ps
`include "pifb_defs.svh"
module pifb_flag_bank_checker
(
   // watched ports
   input wire logic                      MCLK_I,
   input wire logic                      RST_N_I,
   input wire logic [`PIFB_ADDR_W-1:0]   ADDR_I,
   input wire logic                      RD_I,
   input wire logic                      WR_I,
   input wire logic [7:0]                RDATA_O,
   input wire logic                      TIMER1_OVERFLOW_I,
   input wire logic                      TIMER2_MATCH_I,
   input wire logic                      TIMER5_GATE_I,
   input wire logic                      MEMORY_SCAN_I,
   input wire pifb_pkg::pifb_ccmode_type CAPCOMP1_MODE_I,
   input wire logic                      CAPCOMP1_CAPTURE_I,
   input wire logic                      ASYNC1_TX_DATA_WR_I,
   input wire logic [7:0]                SERIAL_FLAGS_O,
   input wire logic [7:0]                TIMER_FLAGS_O,
   input wire logic [7:0]                GATE_FLAGS_O,
   input wire logic [7:0]                CAPCOMP_FLAGS_O,
   input wire logic [7:0]                SYSTEM_FLAGS_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);
   unmapped_read_a: assert property (RD_I && ADDR_I < 3'h3 |=> RDATA_O == 8'h00)
      else $error("unmapped read not zero");
   unimpl_zero_a: assert property ({TIMER_FLAGS_O[7:6], GATE_FLAGS_O[7:3],
      CAPCOMP_FLAGS_O[7:2], SYSTEM_FLAGS_O[4:1]} == 17'h0_0000) else $error("unimplemented bit set");
   overflow_set_a: assert property (TIMER1_OVERFLOW_I |-> ##2 TIMER_FLAGS_O[0])
      else $error("overflow flag missing");
   match_set_a: assert property (TIMER2_MATCH_I |-> ##2 TIMER_FLAGS_O[1])
      else $error("match flag missing");
   gate_set_a: assert property (TIMER5_GATE_I |-> ##2 GATE_FLAGS_O[2])
      else $error("gate flag missing");
   scan_set_a: assert property (MEMORY_SCAN_I |-> ##2 SYSTEM_FLAGS_O[7])
      else $error("scan flag missing");
   flag_sticky_a: assert property (TIMER_FLAGS_O[0] && !$past(WR_I) |=> TIMER_FLAGS_O[0])
      else $error("flag dropped without write");
   capture_set_a: assert property (CAPCOMP1_CAPTURE_I &&
      CAPCOMP1_MODE_I == pifb_pkg::PIFB_MODE_CAPTURE |-> ##2 CAPCOMP_FLAGS_O[0]) else $error("capture flag missing");
   tx_clear_a: assert property (ASYNC1_TX_DATA_WR_I |-> ##2 !SERIAL_FLAGS_O[4])
      else $error("tx flag not cleared");
   cover property (TIMER1_OVERFLOW_I && WR_I);
   cover property (CAPCOMP1_CAPTURE_I && CAPCOMP1_MODE_I == pifb_pkg::PIFB_MODE_PWM);
   cover property (RD_I && ADDR_I == 3'h0);
endmodule
bind pifb_flag_bank pifb_flag_bank_checker u_chk (.*);

// ==== tb/pifb_async_model.sv ====
// Purpose: buffer levels of the two async ports
// Assumes: strobes are one-cycle pulses
// Notes:   tx buffer drains TX_CYC cycles after a write
`timescale 1ns/1ps
module pifb_async_model
#(
   parameter int TX_CYC = 4
)
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // index 1 is port two
   input  wire logic [1:0] rx_in_i,
   input  wire logic [1:0] rd_i,
   input  wire logic [1:0] wr_i,
   // levels
   output logic      [1:0] rx_full_o,
   output logic      [1:0] tx_empty_o
);
   logic [3:0] cnt_q [2];
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rx_full_o <= 2'h0;
         cnt_q <= '{default: 4'h0};
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (rd_i[i]) rx_full_o[i] <= 1'b0;
            else if (rx_in_i[i]) rx_full_o[i] <= 1'b1;
            if (wr_i[i]) cnt_q[i] <= 4'(TX_CYC);
            else if (cnt_q[i] != 4'h0) cnt_q[i] <= cnt_q[i] - 4'h1;
         end
      end
   end
   assign tx_empty_o = {cnt_q[1] == 4'h0, cnt_q[0] == 4'h0};
endmodule

// ==== tb/tb_pifb_flag_bank.sv ====
// Purpose: register-level test of the flag bank
// Assumes: events enter through one 40-bit vector
// Notes:   idle async ports read as 8'h50
`timescale 1ns/1ps
`include "pifb_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
   $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_pifb_flag_bank;
   logic       MCLK_I, RST_N_I, WR_I, RD_I;
   logic [2:0] ADDR_I;
   logic [7:0] WDATA_I, RDATA_O, SERIAL_FLAGS_O, TIMER_FLAGS_O, GATE_FLAGS_O, CAPCOMP_FLAGS_O, SYSTEM_FLAGS_O;
   pifb_pkg::pifb_ccmode_type CAPCOMP2_MODE_I, CAPCOMP1_MODE_I;
   wire        SYNC2_COLLISION_I, SYNC2_DONE_I, SYNC1_COLLISION_I, SYNC1_DONE_I, TIMER6_MATCH_I;
   wire        TIMER5_OVERFLOW_I, TIMER4_MATCH_I, TIMER3_OVERFLOW_I, TIMER2_MATCH_I, TIMER1_OVERFLOW_I;
   wire        TIMER5_GATE_I, TIMER3_GATE_I, TIMER1_GATE_I, CAPCOMP2_CAPTURE_I, CAPCOMP1_CAPTURE_I;
   wire        CAPCOMP2_MATCH_I, CAPCOMP1_MATCH_I, MEMORY_SCAN_I, CHECKSUM_UNIT_I, NONVOLATILE_CTRL_I;
   wire        WAVEFORM_GEN_I, ASYNC2_RX_FULL_I, ASYNC2_TX_EMPTY_I, ASYNC1_RX_FULL_I, ASYNC1_TX_EMPTY_I;
   wire        ASYNC2_RX_DATA_RD_I, ASYNC2_TX_DATA_WR_I, ASYNC1_RX_DATA_RD_I, ASYNC1_TX_DATA_WR_I;
   logic [39:0] ev;
   logic [7:0]  m, x;
   logic [1:0]  rxl, rdp, wrp;
   int          n_errors = 0;
   int          checks_done = 0;
   int          cyc = 0;
   assign {SYNC2_COLLISION_I, SYNC2_DONE_I, SYNC1_COLLISION_I, SYNC1_DONE_I} = ev[3:0];
   assign {TIMER6_MATCH_I, TIMER5_OVERFLOW_I, TIMER4_MATCH_I, TIMER3_OVERFLOW_I, TIMER2_MATCH_I,
           TIMER1_OVERFLOW_I} = ev[13:8];
   assign {TIMER5_GATE_I, TIMER3_GATE_I, TIMER1_GATE_I} = ev[18:16];
   assign {CAPCOMP2_MATCH_I, CAPCOMP1_MATCH_I, CAPCOMP2_CAPTURE_I, CAPCOMP1_CAPTURE_I} = ev[27:24];
   assign {MEMORY_SCAN_I, CHECKSUM_UNIT_I, NONVOLATILE_CTRL_I, WAVEFORM_GEN_I} = {ev[39:37], ev[32]};
   assign {ASYNC2_RX_DATA_RD_I, ASYNC1_RX_DATA_RD_I} = rdp;
   assign {ASYNC2_TX_DATA_WR_I, ASYNC1_TX_DATA_WR_I} = wrp;
   pifb_flag_bank dut (.*);
   pifb_async_model #(.TX_CYC(4)) u_async (.clk_i(MCLK_I), .rst_n_i(RST_N_I), .rx_in_i(rxl), .rd_i(rdp),
      .wr_i(wrp), .rx_full_o({ASYNC2_RX_FULL_I, ASYNC1_RX_FULL_I}),
      .tx_empty_o({ASYNC2_TX_EMPTY_I, ASYNC1_TX_EMPTY_I}));
   initial
   begin
      MCLK_I = 1'b0;
      forever #20 MCLK_I = ~MCLK_I;
   end
   task automatic end_sim();
      if (n_errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge MCLK_I)
   begin
      cyc++;
      if (cyc > 2000)
      begin
         n_errors++;
         end_sim();
      end
   end
   // write with an event pulse in the same cycle
   task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic [39:0] e);
      @(posedge MCLK_I);
      WR_I <= 1'b1;
      ADDR_I <= a;
      WDATA_I <= d;
      ev <= e;
      @(posedge MCLK_I);
      WR_I <= 1'b0;
      ev <= '0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge MCLK_I);
      RD_I <= 1'b1;
      ADDR_I <= a;
      @(posedge MCLK_I);
      RD_I <= 1'b0;
      #1 `CHK(RDATA_O, e)
   endtask
   task automatic acc(input logic [1:0] r, input logic [1:0] w, input logic [7:0] e);
      @(posedge MCLK_I);
      rdp <= r;
      wrp <= w;
      @(posedge MCLK_I);
      rdp <= 2'h0;
      wrp <= 2'h0;
      rd(3'h3, e);
   endtask
   function automatic logic [7:0] msk(input int r);
      case (r)
         3: return `PIFB_MASK_SERIAL_SW;
         4: return `PIFB_MASK_TIMER;
         5: return `PIFB_MASK_GATE;
         6: return `PIFB_MASK_CAPCOMP;
         default: return `PIFB_MASK_SYSTEM;
      endcase
   endfunction
   initial
   begin
      {RST_N_I, WR_I, RD_I, ADDR_I, WDATA_I, ev, rxl, rdp, wrp} = '0;
      CAPCOMP2_MODE_I = pifb_pkg::PIFB_MODE_CAPTURE;
      CAPCOMP1_MODE_I = pifb_pkg::PIFB_MODE_CAPTURE;
      repeat (6) @(posedge MCLK_I);
      RST_N_I <= 1'b1;
      for (int r = 0; r < 8; r++)
         rd(3'(r), r == 3 ? 8'h50 : 8'h00);
      for (int r = 3; r < 8; r++)
      begin
         m = msk(r);
         x = r == 3 ? 8'h50 : 8'h00;
         for (int b = 0; b < 8; b++)
         begin
            if (m[b])
            begin
               wr(3'h0, 8'hFF, 40'h1 << (8 * (r - 3) + b));
               rd(3'(r), x | (8'h01 << b));
               wr(3'(r), 8'h00, 40'h1 << (8 * (r - 3) + b));
               rd(3'(r), x | (8'h01 << b));
               wr(3'(r), 8'h00, 40'h0);
               rd(3'(r), x);
            end
         end
         wr(3'(r), 8'hFF, 40'h0);
         rd(3'(r), x | m);
      end
      RST_N_I <= 1'b0;
      repeat (6) @(posedge MCLK_I);
      RST_N_I <= 1'b1;
      for (int r = 3; r < 8; r++)
         rd(3'(r), r == 3 ? 8'h50 : 8'h00);
      CAPCOMP1_MODE_I <= pifb_pkg::PIFB_MODE_PWM;
      CAPCOMP2_MODE_I <= pifb_pkg::PIFB_MODE_PWM;
      wr(3'h0, 8'h00, 40'hF << 24);
      rd(3'h6, 8'h00);
      CAPCOMP1_MODE_I <= pifb_pkg::PIFB_MODE_COMPARE;
      CAPCOMP2_MODE_I <= pifb_pkg::PIFB_MODE_COMPARE;
      wr(3'h0, 8'h00, 40'h3 << 24);
      rd(3'h6, 8'h00);
      wr(3'h0, 8'h00, 40'hC << 24);
      rd(3'h6, 8'h03);
      @(posedge MCLK_I);
      rxl <= 2'h3;
      @(posedge MCLK_I);
      rxl <= 2'h0;
      rd(3'h3, 8'hF0);
      acc(2'h1, 2'h2, 8'h90);
      repeat (6) @(posedge MCLK_I);
      rd(3'h3, 8'hD0);
      acc(2'h2, 2'h1, 8'h40);
      repeat (6) @(posedge MCLK_I);
      rd(3'h3, 8'h50);
      end_sim();
   end
endmodule
